// ### verilog/wut_top.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "wut_map.svh"
module wut_top import wut_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic SLEEP_REQ,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  output logic IRQ,
  output logic SLEEP_STATE,
  output logic RETAIN_MEM_POWER,
  output logic WAKE_UP,
  output logic RC_OSC_ENABLE,
  output logic CRYSTAL_OSC_ENABLE,
  output logic TIMER_SOURCE_SELECT,
  output logic [3:0] RC_TRIM
);
  // =====================================================
  // helpers
  function automatic logic hit(input logic [13:0] a,
                               input logic [11:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  function automatic logic [16:0] div_of(input logic [2:0] c);
    case (c)
      3'h0: div_of = 17'h00001;
      3'h1: div_of = 17'h00004;
      3'h2: div_of = 17'h00008;
      3'h3: div_of = 17'h00010;
      3'h4: div_of = 17'h00080;
      3'h5: div_of = 17'h00400;
      3'h6: div_of = 17'h02000;
      default: div_of = 17'h10000;
    endcase
  endfunction

  // rc rate per core cycle; undefined trim codes run nominal
  function automatic logic [25:0] rc_step(input logic [3:0] t);
    case (t)
      4'h0: rc_step = 26'd59965;
      4'h1: rc_step = 26'd54395;
      4'h8: rc_step = 26'd49152;
      4'h9: rc_step = 26'd43581;
      4'hc: rc_step = 26'd38011;
      4'he: rc_step = 26'd27525;
      4'hf: rc_step = 26'd21955;
      4'h6: rc_step = 26'd16384;
      4'h7: rc_step = 26'd11141;
      default: rc_step = `WUT_SLOW_HZ;
    endcase
  endfunction

  // =====================================================
  // apb slave, zero wait states
  logic setup;
  logic wr_take;
  logic mapped;
  assign setup = PSEL && !PENABLE;
  assign wr_take = PSEL && PENABLE && PREADY && PWRITE;
  always_comb begin
    if (hit(PADDR, `WUT_IDX_CFG_UP)) mapped = 1'b1;
    else if (hit(PADDR, `WUT_IDX_CFG_LO)) mapped = 1'b1;
    else if (hit(PADDR, `WUT_IDX_RLD_UP)) mapped = 1'b1;
    else if (hit(PADDR, `WUT_IDX_RLD_LO)) mapped = 1'b1;
    else if (hit(PADDR, `WUT_IDX_FLAG_CLR)) mapped = 1'b1;
    else if (hit(PADDR, `WUT_IDX_STATUS)) mapped = 1'b1;
    else if (hit(PADDR, `WUT_IDX_IRQ_STAT)) mapped = 1'b1;
    else if (hit(PADDR, `WUT_IDX_IRQ_MASK)) mapped = 1'b1;
    else mapped = 1'b0;
  end

  logic wr_cfg_up, wr_cfg_lo, wr_rld_up, wr_rld_lo;
  logic wr_flag, wr_istat, wr_imask;
  assign wr_cfg_up = wr_take && hit(PADDR, `WUT_IDX_CFG_UP);
  assign wr_cfg_lo = wr_take && hit(PADDR, `WUT_IDX_CFG_LO);
  assign wr_rld_up = wr_take && hit(PADDR, `WUT_IDX_RLD_UP);
  assign wr_rld_lo = wr_take && hit(PADDR, `WUT_IDX_RLD_LO);
  assign wr_flag = wr_take && hit(PADDR, `WUT_IDX_FLAG_CLR);
  assign wr_istat = wr_take && hit(PADDR, `WUT_IDX_IRQ_STAT);
  assign wr_imask = wr_take && hit(PADDR, `WUT_IDX_IRQ_MASK);

  logic [7:0] status;
  logic [1:0] irq_stat, irq_mask;
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0;
    if (hit(PADDR, `WUT_IDX_STATUS)) next_prdata = {24'h0, status};
    else if (hit(PADDR, `WUT_IDX_IRQ_STAT))
      next_prdata = {30'h0, irq_stat};
    else if (hit(PADDR, `WUT_IDX_IRQ_MASK))
      next_prdata = {30'h0, irq_mask};
    else next_prdata = 32'h0;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      if (setup && !PWRITE) PRDATA <= next_prdata;
    end
  end

  // =====================================================
  // sleep request pin, two-stage synchroniser
  logic req_s1, req_s2, req_s3;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= SLEEP_REQ;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end
  logic sleep_enter;
  wut_pwr_t pwr;
  assign sleep_enter = req_s2 && !req_s3 && pwr == WUT_AWAKE;

  // =====================================================
  // configuration memory bytes and working settings
  logic [7:0] cfg_up_mem;
  logic [7:0] rld_up_mem;
  logic [6:0] cfg_up;
  logic [6:0] cfg_lo;
  wut_word_t reload;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_up_mem <= `WUT_RESET_BYTE;
      rld_up_mem <= `WUT_RESET_BYTE;
    end else if (sleep_enter) begin
      cfg_up_mem <= `WUT_RESET_BYTE;
      rld_up_mem <= `WUT_RESET_BYTE;
    end else begin
      if (wr_cfg_up) cfg_up_mem <= PWDATA[7:0];
      if (wr_rld_up) rld_up_mem <= PWDATA[7:0];
    end
  end

  // upper byte takes effect together with the lower write
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_up <= 7'h0;
      cfg_lo <= 7'h0;
      reload <= 16'h0;
    end else begin
      if (wr_cfg_lo) begin
        cfg_up <= cfg_up_mem[6:0];
        cfg_lo <= PWDATA[6:0];
      end
      if (wr_rld_lo) reload <= {rld_up_mem, PWDATA[7:0]};
    end
  end

  logic src_rc, src_on, arm;
  assign src_rc = cfg_lo[`WUT_LO_SRC];
  assign src_on = src_rc ? cfg_lo[`WUT_LO_RC_EN]
                         : cfg_lo[`WUT_LO_XO_EN];
  assign arm = cfg_lo[`WUT_LO_ARM];

  // =====================================================
  // timer clock as a fractional enable: 32.768 khz from the crystal, trim-dependent rate from rc
  logic [25:0] acc, step;
  logic slow_tick;
  assign step = src_rc ? rc_step(cfg_up[`WUT_UP_TRIM])
                       : `WUT_SLOW_HZ;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc <= 26'h0;
      slow_tick <= 1'b0;
    end else if (!src_on) begin
      acc <= 26'h0;
      slow_tick <= 1'b0;
    end else if (acc + step >= `WUT_CORE_HZ) begin
      acc <= acc + step - `WUT_CORE_HZ;
      slow_tick <= 1'b1;
    end else begin
      acc <= acc + step;
      slow_tick <= 1'b0;
    end
  end

  // prescaler
  logic [15:0] div_cnt;
  logic presc_tick;
  logic [16:0] div;
  assign div = div_of(cfg_up[`WUT_UP_PRESC]);
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_cnt <= 16'h0;
      presc_tick <= 1'b0;
    end else if (wr_cfg_lo) begin
      div_cnt <= 16'h0;
      presc_tick <= 1'b0;
    end else if (slow_tick) begin
      if ({1'b0, div_cnt} + 17'h1 >= div) begin
        div_cnt <= 16'h0;
        presc_tick <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 16'h1;
        presc_tick <= 1'b0;
      end
    end else begin
      presc_tick <= 1'b0;
    end
  end

  // =====================================================
  // countdown; reaching zero reloads on the next tick
  wut_word_t count;
  logic timeout_evt;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      count <= 16'h0;
      timeout_evt <= 1'b0;
    end else if (wr_rld_lo) begin
      count <= {rld_up_mem, PWDATA[7:0]};
      timeout_evt <= 1'b0;
    end else if (presc_tick) begin
      count <= (count == 16'h0) ? reload : count - 16'h1;
      timeout_evt <= (count == 16'h1);
    end else begin
      timeout_evt <= 1'b0;
    end
  end

  // flags: set wins over clear
  logic to_flag, cold_flag;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      to_flag <= 1'b0;
      cold_flag <= 1'b1;
    end else begin
      if (timeout_evt) to_flag <= 1'b1;
      else if (wr_flag && PWDATA[0]) to_flag <= 1'b0;
      if (wr_flag && PWDATA[0]) cold_flag <= 1'b0;
    end
  end
  assign status = {5'h0, cold_flag, to_flag, count == 16'h0};

  // =====================================================
  // power state; a wake seen with entry is dropped and the part goes to sleep
  logic wake_evt;
  assign wake_evt = timeout_evt && arm;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pwr <= WUT_AWAKE;
      WAKE_UP <= 1'b0;
    end else begin
      WAKE_UP <= wake_evt && pwr == WUT_ASLEEP;
      case (pwr)
        WUT_AWAKE: if (sleep_enter) pwr <= WUT_ASLEEP;
        WUT_ASLEEP: if (wake_evt) pwr <= WUT_AWAKE;
        default: pwr <= WUT_AWAKE;
      endcase
    end
  end

  // pin outputs
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SLEEP_STATE <= 1'b0;
      RETAIN_MEM_POWER <= 1'b1;
      RC_OSC_ENABLE <= 1'b0;
      CRYSTAL_OSC_ENABLE <= 1'b0;
      TIMER_SOURCE_SELECT <= 1'b0;
      RC_TRIM <= 4'h0;
    end else begin
      SLEEP_STATE <= pwr == WUT_ASLEEP;
      RETAIN_MEM_POWER <= pwr == WUT_AWAKE
                          || cfg_lo[`WUT_LO_RETAIN];
      RC_OSC_ENABLE <= cfg_lo[`WUT_LO_RC_EN];
      CRYSTAL_OSC_ENABLE <= cfg_lo[`WUT_LO_XO_EN];
      TIMER_SOURCE_SELECT <= src_rc;
      RC_TRIM <= cfg_up[`WUT_UP_TRIM];
    end
  end

  // =====================================================
  // interrupts: bit0 timeout, bit1 wake, write one to clear
  logic [1:0] ev;
  assign ev = {wake_evt, timeout_evt};
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      irq_stat <= ev | (irq_stat & ~(wr_istat ? PWDATA[1:0] : 2'h0));
      if (wr_imask) irq_mask <= PWDATA[1:0];
      IRQ <= |(irq_stat & irq_mask);
    end
  end

  // =====================================================
  // checks
  property p_presc;
    @(posedge CORE_CLK) disable iff (!RESETN)
    presc_tick |-> ({1'b0, $past(div_cnt)} + 17'h1 >= div);
  endproperty
  a_presc: assert property (p_presc) else $error("early tick");

  property p_src;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (src_rc && !cfg_lo[`WUT_LO_RC_EN]) |=> !slow_tick;
  endproperty
  a_src: assert property (p_src) else $error("tick off source");

  property p_trim;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (src_rc && cfg_up[`WUT_UP_TRIM] == `WUT_TRIM_NOMINAL)
      |-> step == `WUT_SLOW_HZ;
  endproperty
  a_trim: assert property (p_trim) else $error("trim rate");

  property p_retain;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (pwr == WUT_ASLEEP && !cfg_lo[`WUT_LO_RETAIN])
      |=> !RETAIN_MEM_POWER;
  endproperty
  a_retain: assert property (p_retain) else $error("retain");

  property p_arm;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (timeout_evt && !arm && pwr == WUT_ASLEEP)
      |=> pwr == WUT_ASLEEP && !WAKE_UP;
  endproperty
  a_arm: assert property (p_arm) else $error("unarmed wake");

  property p_pend;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (wr_rld_up && !wr_rld_lo) |=> $stable(reload);
  endproperty
  a_pend: assert property (p_pend) else $error("reload early");

  property p_sleep;
    @(posedge CORE_CLK) disable iff (!RESETN)
    sleep_enter |=> cfg_up_mem == 8'h00 && rld_up_mem == 8'h00;
  endproperty
  a_sleep: assert property (p_sleep) else $error("bytes kept");

  property p_count;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (presc_tick && !wr_rld_lo && count != 16'h0)
      |=> count == $past(count) - 16'h1;
  endproperty
  a_count: assert property (p_count) else $error("countdown");

  property p_flag;
    @(posedge CORE_CLK) disable iff (!RESETN)
    timeout_evt |=> to_flag ##1 (to_flag || $past(wr_flag));
  endproperty
  a_flag: assert property (p_flag) else $error("flag lost");
endmodule // wut_top

// ### inc/wut_map.svh
`ifndef WUT_MAP_SVH
`define WUT_MAP_SVH
// =====================================================
// register indices, byte address is four times these
`define WUT_IDX_CFG_UP 12'h30c
`define WUT_IDX_CFG_LO 12'h30d
`define WUT_IDX_RLD_UP 12'h30e
`define WUT_IDX_RLD_LO 12'h30f
`define WUT_IDX_FLAG_CLR 12'h310
`define WUT_IDX_STATUS 12'h311
`define WUT_IDX_IRQ_STAT 12'h320
`define WUT_IDX_IRQ_MASK 12'h321
// =====================================================
// field positions
`define WUT_UP_TRIM 6:3
`define WUT_UP_PRESC 2:0
`define WUT_LO_RC_EN 6
`define WUT_LO_XO_EN 5
`define WUT_LO_SRC 4
`define WUT_LO_RETAIN 3
`define WUT_LO_ARM 0
`define WUT_RESET_BYTE 8'h00
`define WUT_TRIM_NOMINAL 4'hd
// =====================================================
// timing
`define WUT_CORE_HZ 26'd40000000
`define WUT_SLOW_HZ 26'd32768
`endif

// ### inc/wut_pkg.sv
package wut_pkg;
  typedef enum logic {WUT_AWAKE, WUT_ASLEEP} wut_pwr_t;
  typedef logic [15:0] wut_word_t;
endpackage

// ### bench/wake_up_timer_config_tb.sv
`timescale 1ns/1ps
`include "wut_map.svh"
module wake_up_timer_config_tb;
  logic CORE_CLK, RESETN, PSEL, PENABLE, PWRITE, SLEEP_REQ;
  logic [13:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic PREADY, PSLVERR, IRQ, SLEEP_STATE, RETAIN_MEM_POWER, WAKE_UP, err;
  logic RC_OSC_ENABLE, CRYSTAL_OSC_ENABLE, TIMER_SOURCE_SELECT;
  logic [3:0] RC_TRIM;
  logic [6:0] prev;
  int n_errors = 0, num_checks = 0, cnt, d;
  typedef struct packed {
    logic [7:0] up;
    logic [7:0] lo;
    logic [6:0] ex;
  } wut_row_t;
  // upper byte, lower byte, expected {rc, xtal, source, trim}
  wut_row_t rows [10] = '{'{8'h00, 8'h40, 7'h40}, '{8'h09, 8'h20, 7'h21},
    '{8'h42, 8'h18, 7'h18}, '{8'h4b, 8'h70, 7'h79},
    '{8'h64, 8'h00, 7'h0c}, '{8'h6d, 8'h50, 7'h5d},
    '{8'h76, 8'h28, 7'h2e}, '{8'h7f, 8'h60, 7'h6f},
    '{8'h30, 8'h10, 7'h16}, '{8'h39, 8'h30, 7'h37}};

  wut_top i_wut_top (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .SLEEP_REQ(SLEEP_REQ), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .SLEEP_STATE(SLEEP_STATE),
    .RETAIN_MEM_POWER(RETAIN_MEM_POWER), .WAKE_UP(WAKE_UP),
    .RC_OSC_ENABLE(RC_OSC_ENABLE), .CRYSTAL_OSC_ENABLE(CRYSTAL_OSC_ENABLE),
    .TIMER_SOURCE_SELECT(TIMER_SOURCE_SELECT), .RC_TRIM(RC_TRIM));

  initial begin
    CORE_CLK = 1'h0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end

  // =====================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic clk(input int k);
    repeat (k) @(posedge CORE_CLK);
  endtask

  function automatic logic [6:0] outs();
    return {RC_OSC_ENABLE, CRYSTAL_OSC_ENABLE, TIMER_SOURCE_SELECT, RC_TRIM};
  endfunction

  function automatic logic pick(input int s);
    return s == 0 ? IRQ : (s == 1 ? SLEEP_STATE : WAKE_UP);
  endfunction

  // one idle edge after release so the next setup never lands in this step
  task automatic apb(input logic w, input logic [11:0] idx,
                     input logic [31:0] dat);
    int k;
    k = 0;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= {idx, 2'h0};
    PWDATA <= dat;
    @(posedge CORE_CLK);
    PENABLE <= 1'h1;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (PREADY !== 1'h1 && k < 16);
    if (PREADY !== 1'h1) begin
      n_errors++;
      $display("MISMATCH t=%0t bus transfer never answered", $time);
      end_sim;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CORE_CLK);
  endtask

  // cnt keeps the elapsed cycles, used for period measurements
  task automatic wait_hi(input int s, input int lim);
    cnt = 0;
    while (pick(s) !== 1'h1 && cnt < lim) begin
      @(posedge CORE_CLK);
      cnt++;
    end
    if (cnt >= lim) begin
      n_errors++;
      $display("MISMATCH t=%0t wait for event timed out", $time);
      end_sim;
    end
  endtask

  task automatic timer(input logic [2:0] p, input logic [7:0] lo,
                       input logic [7:0] r);
    apb(1'h1, `WUT_IDX_CFG_UP, {25'h0, 4'hd, p});
    apb(1'h1, `WUT_IDX_CFG_LO, {24'h0, lo});
    apb(1'h1, `WUT_IDX_RLD_UP, 32'h0);
    apb(1'h1, `WUT_IDX_RLD_LO, {24'h0, r});
    apb(1'h1, `WUT_IDX_IRQ_STAT, 32'h3);
  endtask

  task automatic do_reset;
    RESETN <= 1'h0;
    clk(10);
    RESETN <= 1'h1;
    clk(1);
  endtask

  // =====================================================
  // main sequence
  initial begin
    RESETN = 1'h0;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 14'h0;
    PWDATA = 32'h0;
    SLEEP_REQ = 1'h0;
    do_reset;
    chk({IRQ, SLEEP_STATE, RETAIN_MEM_POWER, WAKE_UP, outs()}, 32'h100,
        "reset outputs");
    apb(1'h0, `WUT_IDX_STATUS, 32'h0);
    // counter idles at zero after reset, so the live bit reads set
    chk(rd[2:0], 3'h5, "cold start flag");
    apb(1'h0, `WUT_IDX_CFG_UP, 32'h0);
    chk(rd, 32'h0, "write-only reads zero");
    apb(1'h0, 12'h200, 32'h0);
    chk(err, 1'h1, "unmapped address error");
    $display("test reset done");
    prev = 7'h0;
    foreach (rows[i]) begin
      apb(1'h1, `WUT_IDX_CFG_UP, {24'h0, rows[i].up});
      clk(2);
      chk(outs(), prev, "upper byte applied alone");
      apb(1'h1, `WUT_IDX_CFG_LO, {24'h0, rows[i].lo});
      clk(2);
      chk(outs(), rows[i].ex, "config row");
      chk(RETAIN_MEM_POWER, 1'h1, "memory power awake");
      prev = rows[i].ex;
    end
    $display("test config table done");
    // reload 3 gives a period of 4 ticks, since the zero count takes one tick before the reload
    for (int p = 0; p < 2; p++) begin
      d = (p == 0) ? 1221 : 4884;
      timer(p[2:0], 8'h20, 8'h03);
      apb(1'h1, `WUT_IDX_IRQ_MASK, 32'h1);
      wait_hi(0, 25000);
      apb(1'h1, `WUT_IDX_IRQ_STAT, 32'h1);
      // irq output lags the cleared status by one edge
      clk(2);
      wait_hi(0, 25000);
      chk(cnt > 3 * d - 1300 && cnt < 4 * d + 1300, 1'h1,
          "tick period");
    end
    apb(1'h0, `WUT_IDX_STATUS, 32'h0);
    chk(rd[2:1], 2'h3, "latched flags");
    apb(1'h1, `WUT_IDX_FLAG_CLR, 32'h1);
    apb(1'h0, `WUT_IDX_STATUS, 32'h0);
    chk(rd[2:1], 2'h0, "flags cleared");
    $display("test timer periods done");
    timer(3'h0, 8'h20, 8'h03);
    apb(1'h1, `WUT_IDX_RLD_UP, 32'h7f);
    apb(1'h1, `WUT_IDX_IRQ_MASK, 32'h0);
    // the first timeout comes from the loaded count; only the second
    // one goes through the reload and shows whether the pending byte leaked
    for (int j = 0; j < 2; j++) begin
      apb(1'h1, `WUT_IDX_IRQ_STAT, 32'h3);
      cnt = 0;
      do begin
        apb(1'h0, `WUT_IDX_IRQ_STAT, 32'h0);
        cnt++;
      end while (rd[0] !== 1'h1 && cnt < 3000);
    end
    chk(cnt < 3000, 1'h1, "pending upper reload not applied");
    chk(IRQ, 1'h0, "masked interrupt");
    apb(1'h1, `WUT_IDX_IRQ_MASK, 32'h1);
    clk(1);
    chk(IRQ, 1'h1, "unmasked interrupt");
    apb(1'h1, `WUT_IDX_IRQ_STAT, 32'h1);
    clk(1);
    chk(IRQ, 1'h0, "interrupt cleared");
    $display("test reload and interrupt done");
    timer(3'h0, 8'h20, 8'h01);
    SLEEP_REQ <= 1'h1;
    wait_hi(1, 20);
    chk(RETAIN_MEM_POWER, 1'h0, "memory power dropped");
    cnt = 0;
    repeat (8000) begin
      @(posedge CORE_CLK);
      if (WAKE_UP !== 1'h0)
        cnt++;
    end
    chk(cnt, 32'h0, "unarmed timeout woke");
    SLEEP_REQ <= 1'h0;
    do_reset;
    timer(3'h0, 8'h28, 8'h01);
    apb(1'h1, `WUT_IDX_CFG_LO, 32'h29);
    SLEEP_REQ <= 1'h1;
    wait_hi(1, 20);
    chk(RETAIN_MEM_POWER, 1'h1, "memory power kept");
    wait_hi(2, 8000);
    chk(WAKE_UP, 1'h1, "armed wake pulse");
    SLEEP_REQ <= 1'h0;
    clk(4);
    apb(1'h0, `WUT_IDX_IRQ_STAT, 32'h0);
    chk(rd[1], 1'h1, "wake status bit");
    apb(1'h1, `WUT_IDX_CFG_LO, 32'h50);
    clk(2);
    chk(outs(), 7'h50, "upper byte lost in sleep");
    $display("test sleep and wake done");
    end_sim;
  end
endmodule // wake_up_timer_config_tb
